/* File: sim/bit_shift_flag_exec_unit_test.sv */
`timescale 1ns/1ps
module bit_shift_flag_exec_unit_test import bsfx_pkg::*; ;
  logic ref_clk;
  logic rst_b;
  logic cmd_valid;
  bsfx_op_type cmd_op;
  logic [4:0] cmd_reg;
  logic [2:0] cmd_bit;
  logic [3:0] cmd_io;
  logic cmd_ready;
  logic cmd_done;
  logic sleep_req;
  logic wdt_restart;
  logic [7:0] status_flags;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_rdata;
  int error_cnt;
  int n_checks;
  bsfx_op_type sh_ops [6] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_THRU_CARRY,
    OP_ROTATE_RIGHT_THRU_CARRY, OP_SHIFT_RIGHT_ARITH, OP_NIBBLE_SWAP};
  logic [7:0] sh_vals [3] = '{8'h81, 8'h40, 8'h01};
  // Named flag ops, indexed by flag position C Z N V S H T I
  bsfx_op_type f_one [8] = '{OP_CARRY_ONE, OP_ZFLAG_ONE, OP_NEG_ONE, OP_OVERFLOW_FORCE_ONE, OP_SIGN_ONE,
    OP_HALF_CARRY_FORCE_ONE, OP_TFLAG_ONE, OP_GLOBAL_IRQ_ON};
  bsfx_op_type f_zero [8] = '{OP_CARRY_ZERO, OP_ZFLAG_ZERO, OP_NEG_ZERO, OP_OVERFLOW_FORCE_ZERO, OP_SIGN_ZERO,
    OP_HALF_CARRY_FORCE_ZERO, OP_TFLAG_ZERO, OP_GLOBAL_IRQ_OFF};
  bsfx_op_type misc_ops [3] = '{OP_NOP, OP_SLEEP, OP_WATCHDOG_RESTART};

  bsfx_exec_unit bsfx_exec_unit_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_reg(cmd_reg),
    .cmd_bit(cmd_bit), .cmd_io(cmd_io), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .sleep_req(sleep_req),
    .wdt_restart(wdt_restart), .status_flags(status_flags), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata)
  );

  // Free-running core clock, 20 ns period
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic results();
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  // Read data is looked at mid-cycle, away from the launching edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(negedge ref_clk);
    chk(bus_rdata, exp);
  endtask

  // Offers one op, counts cycles to done; a hung unit gives up after 6
  task automatic run_op(input bsfx_op_type op, input logic [4:0] r, input logic [2:0] b, input logic [3:0] io,
                        input int cyc);
    int n;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_reg <= r;
    cmd_bit <= b;
    cmd_io <= io;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 1;
    @(negedge ref_clk);
    if (cyc == CYC_LONG) chk({7'h00, cmd_ready}, 8'h00);
    while (cmd_done !== 1'b1 && n < 6) begin
      @(posedge ref_clk);
      n++;
      @(negedge ref_clk);
    end
    chk(8'(n), 8'(cyc));
    chk({7'h00, sleep_req}, {7'h00, op == OP_SLEEP});
    chk({7'h00, wdt_restart}, {7'h00, op == OP_WATCHDOG_RESTART});
  endtask

  // Reference result and flags of the shift, rotate and swap group
  function automatic logic [15:0] exp_shift(input bsfx_op_type op, input logic [7:0] v, input logic [7:0] f);
    logic [7:0] r;
    logic c;
    logic [7:0] fo;
    c = f[0];
    fo = f;
    case (op)
      OP_SHIFT_LEFT_LOGICAL: begin r = {v[6:0], 1'b0}; c = v[7]; end
      OP_SHIFT_RIGHT_LOGICAL: begin r = {1'b0, v[7:1]}; c = v[0]; end
      OP_ROTATE_LEFT_THRU_CARRY: begin r = {v[6:0], f[0]}; c = v[7]; end
      OP_ROTATE_RIGHT_THRU_CARRY: begin r = {f[0], v[7:1]}; c = v[0]; end
      OP_SHIFT_RIGHT_ARITH: begin r = {v[7], v[7:1]}; c = v[0]; end
      default: r = {v[3:0], v[7:4]};
    endcase
    if (op != OP_NIBBLE_SWAP) fo[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    return {fo, r};
  endfunction

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    results();
  end

  // Main sequence
  initial begin
    logic [7:0] v;
    logic [7:0] fin;
    logic [7:0] m;
    logic [15:0] e;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_NOP;
    cmd_reg = 5'h00;
    cmd_bit = 3'h0;
    cmd_io = 4'h0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk(status_flags, STATUS_FLAGS_RESET);
    rd_chk(STACK_PTR_ADDR, 8'h0f);
    rd_chk(8'h05, DATA_RESET);
    rd_chk(8'h25, DATA_RESET);
    @(negedge ref_clk);
    chk(bus_rdata, 8'h00);
    // Unmapped place ignores writes and reads zero
    bus_write(8'h30, 8'hff);
    rd_chk(8'h30, 8'h00);
    // Every shift kind over edge values, carry in both ways
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        v = sh_vals[j];
        fin = j[0] ? 8'hf1 : 8'h70;
        bus_write(8'h01, v);
        bus_write(STATUS_FLAGS_ADDR, fin);
        run_op(sh_ops[i], 5'h01, 3'h0, 4'h0, CYC_SHORT);
        e = exp_shift(sh_ops[i], v, fin);
        rd_chk(8'h01, e[7:0]);
        chk(status_flags, e[15:8]);
      end
    end
    // Named then generic flag force, from patterns that expose stray bits
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 8; i++) begin
        m = 8'h01 << i;
        bus_write(STATUS_FLAGS_ADDR, 8'h5a & ~m);
        run_op(k[0] ? OP_STATUS_BIT_FORCE_ONE : f_one[i], 5'h00, 3'(i), 4'h0, CYC_SHORT);
        chk(status_flags, 8'h5a | m);
        bus_write(STATUS_FLAGS_ADDR, 8'ha5 | m);
        run_op(k[0] ? OP_STATUS_BIT_FORCE_ZERO : f_zero[i], 5'h00, 3'(i), 4'h0, CYC_SHORT);
        chk(status_flags, 8'ha5 & ~m);
      end
    end
    // Two pushes, two pops: last in comes out first
    bus_write(STATUS_FLAGS_ADDR, 8'h3c);
    bus_write(8'h06, 8'h9e);
    run_op(OP_PUSH, 5'h06, 3'h0, 4'h0, CYC_LONG);
    bus_write(8'h06, 8'h11);
    run_op(OP_PUSH, 5'h06, 3'h0, 4'h0, CYC_LONG);
    rd_chk(STACK_PTR_ADDR, 8'h0d);
    run_op(OP_POP, 5'h07, 3'h0, 4'h0, CYC_LONG);
    run_op(OP_POP, 5'h08, 3'h0, 4'h0, CYC_LONG);
    rd_chk(8'h07, 8'h11);
    rd_chk(8'h08, 8'h9e);
    rd_chk(STACK_PTR_ADDR, 8'h0f);
    chk(status_flags, 8'h3c);
    // Bit set and clear in one I/O register, neighbour untouched
    bus_write(8'h23, 8'h81);
    run_op(OP_IO_BIT_SET, 5'h00, 3'h4, 4'h3, CYC_LONG);
    rd_chk(8'h23, 8'h91);
    run_op(OP_IO_BIT_CLEAR, 5'h00, 3'h0, 4'h3, CYC_LONG);
    rd_chk(8'h23, 8'h90);
    rd_chk(8'h22, 8'h00);
    chk(status_flags, 8'h3c);
    // Register bit to transfer flag and back
    bus_write(STATUS_FLAGS_ADDR, 8'h00);
    bus_write(8'h03, 8'h20);
    run_op(OP_REG_BIT_TO_TRANSFER_FLAG, 5'h03, 3'h5, 4'h0, CYC_SHORT);
    chk(status_flags, 8'h40);
    bus_write(8'h04, 8'h81);
    run_op(OP_TRANSFER_FLAG_TO_REG_BIT, 5'h04, 3'h2, 4'h0, CYC_SHORT);
    rd_chk(8'h04, 8'h85);
    chk(status_flags, 8'h40);
    run_op(OP_REG_BIT_TO_TRANSFER_FLAG, 5'h03, 3'h0, 4'h0, CYC_SHORT);
    chk(status_flags, 8'h00);
    // No-op, sleep and watchdog restart leave state alone
    for (int i = 0; i < 3; i++) begin
      bus_write(STATUS_FLAGS_ADDR, 8'h96);
      run_op(misc_ops[i], 5'h04, 3'h0, 4'h0, CYC_SHORT);
      chk(status_flags, 8'h96);
      rd_chk(8'h04, 8'h85);
    end
    results();
  end
endmodule

/* File: verilog/bsfx_alu_if.sv */
`timescale 1ns/1ps
interface bsfx_alu_if;
  import bsfx_pkg::*;
  bsfx_op_type op;
  logic [7:0] operand;
  logic [2:0] bit_sel;
  logic [7:0] flags_in;
  logic [7:0] result;
  logic [7:0] flags_out;
  logic reg_we;
  logic flags_we;

  modport alu (input op, input operand, input bit_sel, input flags_in,
               output result, output flags_out, output reg_we, output flags_we);
  modport core (output op, output operand, output bit_sel, output flags_in,
                input result, input flags_out, input reg_we, input flags_we);
endinterface

/* File: verilog/bsfx_exec_unit.sv */
`timescale 1ns/1ps
// What this block does
// [RL1] Push stores the chosen register on the stack, flags unchanged, two cycles.
// [RL2] Pop loads the chosen register from the stack, flags unchanged, two cycles.
// [RL3] I/O bit-set forces one addressed bit to one, two cycles, flags unchanged.
// [RL4] I/O bit-clear forces one addressed bit to zero, two cycles, flags unchanged.
// [RL5] Logical left shift inserts zero at bit 0; Z, C, N, V updated; one cycle.
// [RL6] Logical right shift inserts zero at bit 7; Z, C, N, V updated; one cycle.
// [RL7] Left rotate feeds old carry into bit 0, bit 7 into carry; one cycle.
// [RL8] Right rotate feeds old carry into bit 7, bit 0 into carry; one cycle.
// [RL9] Arithmetic right shift keeps bit 7; Z, C, N, V updated; one cycle.
// [RL10] Nibble swap exchanges register halves in one cycle, no flag changes.
// [RL11] Bit store copies a register bit into the transfer flag only; one cycle.
// [RL12] Bit load copies the transfer flag into one register bit; one cycle.
// [RL13] Single-cycle ops force the overflow flag one or zero, nothing else.
// [RL14] Single-cycle ops force the signed test flag one or zero, nothing else.
// [RL15] Single-cycle ops force the half-carry flag one or zero, nothing else.
// [RL16] Sleep issues in one cycle without flag changes, pulsing the sleep request.
// [RL17] Watchdog restart issues in one cycle without flag changes, pulsing restart.
// [RL18] Set and clear for C, Z, N, T, I, plus generic set/clear by index.
// [RL19] No-operation takes one cycle and changes no state.
module bsfx_exec_unit
  import bsfx_pkg::*;
#(
  parameter int REG_COUNT = REG_COUNT_DEF,
  parameter int IO_COUNT = IO_COUNT_DEF,
  parameter int STACK_DEPTH = STACK_DEPTH_DEF,
  parameter int RW = $clog2(REG_COUNT),
  parameter int IW = $clog2(IO_COUNT),
  parameter int SW = $clog2(STACK_DEPTH)
) (
  input wire logic ref_clk, // Core clock, 50 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic cmd_valid, // Operation offered
  input wire bsfx_op_type cmd_op, // Operation code
  input wire logic [RW-1:0] cmd_reg, // Working register index
  input wire logic [2:0] cmd_bit, // Bit or flag index
  input wire logic [IW-1:0] cmd_io, // I/O register index
  output logic cmd_ready, // Unit can take an operation
  output logic cmd_done, // Operation finished, one cycle
  output logic sleep_req, // Sleep request pulse
  output logic wdt_restart, // Watchdog restart pulse
  output logic [7:0] status_flags, // Current status flags
  input wire logic [7:0] bus_addr, // Register port address
  input wire logic [7:0] bus_wdata, // Register port write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  output logic [7:0] bus_rdata // Read data, cycle after the strobe
);

  localparam logic [7:0] WREG_END = 8'(WREG_BASE + REG_COUNT);
  localparam logic [7:0] IO_END = 8'(IO_BASE + IO_COUNT);
  localparam logic [SW-1:0] SP_TOP = SW'(STACK_DEPTH - 1);

  logic [7:0] wreg_r [REG_COUNT];
  logic [7:0] io_r [IO_COUNT];
  logic [7:0] stack_r [STACK_DEPTH];
  logic [SW-1:0] sp_r;
  logic [SW-1:0] sp_nxt;
  logic [7:0] status_flags_r;
  logic [7:0] status_flags_nxt;
  bsfx_state_type state_r;
  bsfx_state_type state_nxt;
  bsfx_op_type op_r;
  logic [RW-1:0] reg_idx_r;
  logic [IW-1:0] io_idx_r;
  logic [2:0] bit_r;
  logic [7:0] hold_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic done_r;
  logic sleep_r;
  logic wdt_r;

  bsfx_alu_if alu_bus ();

  bsfx_shift_alu u_alu (
    .alu(alu_bus)
  );

  // Command acceptance; long ops hold off the next one for a cycle
  wire cmd_take = cmd_valid && (state_r == ST_IDLE);
  wire long_op = (cmd_op == OP_PUSH) || (cmd_op == OP_POP) ||
                 (cmd_op == OP_IO_BIT_SET) || (cmd_op == OP_IO_BIT_CLEAR);
  wire in_second = (state_r == ST_SECOND);

  assign alu_bus.op = cmd_op;
  assign alu_bus.operand = wreg_r[cmd_reg];
  assign alu_bus.bit_sel = cmd_bit;
  assign alu_bus.flags_in = status_flags_r;

  // Register port decode
  wire sel_wreg = (bus_addr >= WREG_BASE) && (bus_addr < WREG_END);
  wire sel_io = (bus_addr >= IO_BASE) && (bus_addr < IO_END);
  wire sel_sp = (bus_addr == STACK_PTR_ADDR);
  wire sel_flags = (bus_addr == STATUS_FLAGS_ADDR);
  wire [RW-1:0] bus_wreg_idx = RW'(bus_addr - WREG_BASE);
  wire [IW-1:0] bus_io_idx = IW'(bus_addr - IO_BASE);

  // Read mux; unmapped addresses read as zero
  always_comb begin
    if (!bus_rd) begin
      rdata_nxt = DATA_RESET;
    end else if (sel_wreg) begin
      rdata_nxt = wreg_r[bus_wreg_idx];
    end else if (sel_io) begin
      rdata_nxt = io_r[bus_io_idx];
    end else if (sel_sp) begin
      rdata_nxt = 8'(sp_r);
    end else if (sel_flags) begin
      rdata_nxt = status_flags_r;
    end else begin
      rdata_nxt = DATA_RESET;
    end
  end

  // Working register writes from the unit
  wire exec_reg_we = (cmd_take && alu_bus.reg_we) || (in_second && op_r == OP_POP); // RL2 RL12
  wire [RW-1:0] exec_reg_idx = in_second ? reg_idx_r : cmd_reg;
  wire [7:0] exec_reg_val = in_second ? hold_r : alu_bus.result;

  // Second-cycle commits of the long ops
  wire push_commit = in_second && (op_r == OP_PUSH); // RL1
  wire pop_commit = in_second && (op_r == OP_POP); // RL2
  wire io_commit = in_second && ((op_r == OP_IO_BIT_SET) || (op_r == OP_IO_BIT_CLEAR));
  wire [7:0] io_new = (op_r == OP_IO_BIT_SET) ? (io_r[io_idx_r] | bit_mask(bit_r)) // RL3
                                               : (io_r[io_idx_r] & ~bit_mask(bit_r)); // RL4

  // Stack pointer: push post-decrements, pop pre-increments
  assign sp_nxt = push_commit ? SW'(sp_r - 1'b1) :
                  pop_commit ? SW'(sp_r + 1'b1) :
                  (bus_wr && sel_sp) ? SW'(bus_wdata) : sp_r;

  // Unit flag writes beat a software write in the same cycle
  assign status_flags_nxt = (cmd_take && alu_bus.flags_we) ? alu_bus.flags_out :
                            (bus_wr && sel_flags) ? bus_wdata : status_flags_r;

  assign state_nxt = (cmd_take && long_op) ? ST_SECOND : ST_IDLE; // RL1 RL2 RL3 RL4

  // Control state and pulses
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      op_r <= OP_NOP;
      sp_r <= SP_TOP;
      status_flags_r <= STATUS_FLAGS_RESET;
      rdata_r <= DATA_RESET;
      done_r <= 1'b0;
      sleep_r <= 1'b0;
      wdt_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sp_r <= sp_nxt;
      status_flags_r <= status_flags_nxt;
      rdata_r <= rdata_nxt;
      done_r <= (cmd_take && !long_op) || in_second; // RL19
      sleep_r <= cmd_take && (cmd_op == OP_SLEEP); // RL16
      wdt_r <= cmd_take && (cmd_op == OP_WATCHDOG_RESTART); // RL17
      if (cmd_take) begin
        op_r <= cmd_op;
      end
    end
  end

  // Operand capture for the second cycle; no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (cmd_take) begin
      reg_idx_r <= cmd_reg;
      io_idx_r <= cmd_io;
      bit_r <= cmd_bit;
      hold_r <= (cmd_op == OP_POP) ? stack_r[SW'(sp_r + 1'b1)] : wreg_r[cmd_reg]; // RL1 RL2
    end
  end

  // Working registers: a unit write lands after a port write, so it wins
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        wreg_r[i] <= DATA_RESET;
      end
    end else begin
      if (bus_wr && sel_wreg) begin
        wreg_r[bus_wreg_idx] <= bus_wdata;
      end
      if (exec_reg_we) begin
        wreg_r[exec_reg_idx] <= exec_reg_val;
      end
    end
  end

  // I/O registers, same priority as above
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < IO_COUNT; i++) begin
        io_r[i] <= DATA_RESET;
      end
    end else begin
      if (bus_wr && sel_io) begin
        io_r[bus_io_idx] <= bus_wdata;
      end
      if (io_commit) begin
        io_r[io_idx_r] <= io_new; // RL3 RL4
      end
    end
  end

  // Stack memory; wraps silently on overflow, software owns the pointer
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= DATA_RESET;
      end
    end else if (push_commit) begin
      stack_r[sp_r] <= hold_r; // RL1
    end
  end

  assign cmd_ready = (state_r == ST_IDLE);
  assign cmd_done = done_r;
  assign sleep_req = sleep_r;
  assign wdt_restart = wdt_r;
  assign status_flags = status_flags_r;
  assign bus_rdata = rdata_r;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  wire no_flag_wr = !(bus_wr && sel_flags);
  wire no_reg_wr = !(bus_wr && sel_wreg);

  property p_push_two;
    cmd_take && cmd_op == OP_PUSH |=> !cmd_ready && !cmd_done ##1
      cmd_done && stack_r[$past(sp_r)] == $past(hold_r) && sp_r == SW'($past(sp_r) - 1'b1);
  endproperty
  a_push_two: assert property (p_push_two) else $error("push not stored in two cycles"); // RL1

  property p_pop_two;
    cmd_take && cmd_op == OP_POP |-> ##2 cmd_done && wreg_r[reg_idx_r] == stack_r[sp_r];
  endproperty
  a_pop_two: assert property (p_pop_two) else $error("pop not loaded in two cycles"); // RL2

  property p_io_set;
    cmd_take && cmd_op == OP_IO_BIT_SET |-> ##2 io_r[io_idx_r][bit_r] && cmd_done;
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit not set"); // RL3

  property p_io_clear;
    cmd_take && cmd_op == OP_IO_BIT_CLEAR |-> ##2 !io_r[io_idx_r][bit_r] && cmd_done;
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io bit not cleared"); // RL4

  property p_long_flags;
    cmd_take && long_op && no_flag_wr ##1 no_flag_wr |=> status_flags_r == $past(status_flags_r, 2);
  endproperty
  a_long_flags: assert property (p_long_flags) else $error("long op changed flags"); // RL1

  property p_shl;
    cmd_take && cmd_op == OP_SHIFT_LEFT_LOGICAL |=>
      wreg_r[$past(cmd_reg)] == {$past(alu_bus.operand[6:0]), 1'b0} &&
      status_flags_r[FLAG_C] == $past(alu_bus.operand[7]) && cmd_done;
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong"); // RL5

  property p_rotate_right;
    cmd_take && cmd_op == OP_ROTATE_RIGHT_THRU_CARRY |=>
      wreg_r[$past(cmd_reg)][7] == $past(status_flags_r[FLAG_C]) &&
      status_flags_r[FLAG_C] == $past(alu_bus.operand[0]);
  endproperty
  a_rotate_right: assert property (p_rotate_right) else $error("right rotate wrong"); // RL8

  property p_shift_right;
    cmd_take && cmd_op == OP_SHIFT_RIGHT_LOGICAL |=>
      wreg_r[$past(cmd_reg)] == {1'b0, $past(alu_bus.operand[7:1])} &&
      status_flags_r[FLAG_C] == $past(alu_bus.operand[0]);
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("right shift wrong"); // RL6

  property p_rotate_left;
    cmd_take && cmd_op == OP_ROTATE_LEFT_THRU_CARRY |=>
      wreg_r[$past(cmd_reg)] == {$past(alu_bus.operand[6:0]), $past(status_flags_r[FLAG_C])} &&
      status_flags_r[FLAG_C] == $past(alu_bus.operand[7]);
  endproperty
  a_rotate_left: assert property (p_rotate_left) else $error("left rotate wrong"); // RL7

  property p_shift_arith;
    cmd_take && cmd_op == OP_SHIFT_RIGHT_ARITH |=>
      wreg_r[$past(cmd_reg)][7:6] == {2{$past(alu_bus.operand[7])}};
  endproperty
  a_shift_arith: assert property (p_shift_arith) else $error("arith shift lost sign"); // RL9

  property p_swap;
    cmd_take && cmd_op == OP_NIBBLE_SWAP && no_flag_wr |=>
      wreg_r[$past(cmd_reg)] == {$past(alu_bus.operand[3:0]), $past(alu_bus.operand[7:4])} &&
      status_flags_r == $past(status_flags_r);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong"); // RL10

  property p_bit_store;
    cmd_take && cmd_op == OP_REG_BIT_TO_TRANSFER_FLAG |=>
      status_flags_r[FLAG_T] == $past(alu_bus.operand[cmd_bit]) &&
      status_flags_r[5:0] == $past(status_flags_r[5:0]);
  endproperty
  a_bit_store: assert property (p_bit_store) else $error("bit store wrong"); // RL11

  property p_bit_load;
    cmd_take && cmd_op == OP_TRANSFER_FLAG_TO_REG_BIT && no_flag_wr |=>
      wreg_r[$past(cmd_reg)][$past(cmd_bit)] == $past(status_flags_r[FLAG_T]) &&
      status_flags_r == $past(status_flags_r);
  endproperty
  a_bit_load: assert property (p_bit_load) else $error("bit load wrong"); // RL12

  property p_overflow;
    cmd_take && cmd_op == OP_OVERFLOW_FORCE_ONE |=>
      status_flags_r == ($past(status_flags_r) | bit_mask(FLAG_V));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow force wrong"); // RL13

  property p_sign_force;
    cmd_take && cmd_op == OP_SIGN_ZERO |=>
      status_flags_r == ($past(status_flags_r) & ~bit_mask(FLAG_S));
  endproperty
  a_sign_force: assert property (p_sign_force) else $error("sign force wrong"); // RL14

  property p_half_carry_force;
    cmd_take && cmd_op == OP_HALF_CARRY_FORCE_ONE |=>
      status_flags_r == ($past(status_flags_r) | bit_mask(FLAG_H));
  endproperty
  a_half_carry_force: assert property (p_half_carry_force) else $error("half carry force wrong"); // RL15

  property p_generic_force;
    cmd_take && cmd_op == OP_STATUS_BIT_FORCE_ZERO |=>
      status_flags_r == ($past(status_flags_r) & ~bit_mask($past(cmd_bit)));
  endproperty
  a_generic_force: assert property (p_generic_force) else $error("generic flag clear wrong"); // RL18

  property p_sleep;
    cmd_take && cmd_op == OP_SLEEP |=> sleep_req && cmd_done ##1
      sleep_req == $past(cmd_take && cmd_op == OP_SLEEP); // A second sleep may follow at once
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep pulse wrong"); // RL16

  property p_wdt;
    cmd_take && cmd_op == OP_WATCHDOG_RESTART |=> wdt_restart && cmd_ready ##1
      wdt_restart == $past(cmd_take && cmd_op == OP_WATCHDOG_RESTART);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog pulse wrong"); // RL17

  property p_nop;
    cmd_take && cmd_op == OP_NOP && no_flag_wr && no_reg_wr && !(bus_wr && sel_sp) |=>
      cmd_done && cmd_ready && status_flags_r == $past(status_flags_r) && sp_r == $past(sp_r);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state"); // RL19

  c_push_pop: cover property (cmd_take && cmd_op == OP_PUSH ##2 cmd_take && cmd_op == OP_POP);
  c_io_set: cover property (cmd_take && cmd_op == OP_IO_BIT_SET ##2 cmd_done);
  c_rotate_left: cover property (cmd_take && cmd_op == OP_ROTATE_LEFT_THRU_CARRY && status_flags_r[FLAG_C]);
  c_irq_on: cover property (cmd_take && cmd_op == OP_GLOBAL_IRQ_ON ##1 status_flags[FLAG_I]);

endmodule

/* File: verilog/bsfx_pkg.sv */
package bsfx_pkg;

  // Default sizes of the storage arrays
  localparam int REG_COUNT_DEF = 32;
  localparam int IO_COUNT_DEF = 16;
  localparam int STACK_DEPTH_DEF = 16;

  // Register port map (byte addresses)
  localparam logic [7:0] WREG_BASE = 8'h00;
  localparam logic [7:0] IO_BASE = 8'h20;
  localparam logic [7:0] STACK_PTR_ADDR = 8'h3d;
  localparam logic [7:0] STATUS_FLAGS_ADDR = 8'h3f;

  // Values after reset
  localparam logic [7:0] STATUS_FLAGS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Cycle counts per operation class
  localparam int CYC_SHORT = 1;
  localparam int CYC_LONG = 2;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_PUSH = 6'h01,
    OP_POP = 6'h02,
    OP_IO_BIT_SET = 6'h03,
    OP_IO_BIT_CLEAR = 6'h04,
    OP_SHIFT_LEFT_LOGICAL = 6'h05,
    OP_SHIFT_RIGHT_LOGICAL = 6'h06,
    OP_ROTATE_LEFT_THRU_CARRY = 6'h07,
    OP_ROTATE_RIGHT_THRU_CARRY = 6'h08,
    OP_SHIFT_RIGHT_ARITH = 6'h09,
    OP_NIBBLE_SWAP = 6'h0a,
    OP_REG_BIT_TO_TRANSFER_FLAG = 6'h0b,
    OP_TRANSFER_FLAG_TO_REG_BIT = 6'h0c,
    OP_STATUS_BIT_FORCE_ONE = 6'h0d,
    OP_STATUS_BIT_FORCE_ZERO = 6'h0e,
    OP_SLEEP = 6'h0f,
    OP_WATCHDOG_RESTART = 6'h10,
    OP_CARRY_ONE = 6'h11,
    OP_CARRY_ZERO = 6'h12,
    OP_NEG_ONE = 6'h13,
    OP_NEG_ZERO = 6'h14,
    OP_ZFLAG_ONE = 6'h15,
    OP_ZFLAG_ZERO = 6'h16,
    OP_GLOBAL_IRQ_ON = 6'h17,
    OP_GLOBAL_IRQ_OFF = 6'h18,
    OP_SIGN_ONE = 6'h19,
    OP_SIGN_ZERO = 6'h1a,
    OP_OVERFLOW_FORCE_ONE = 6'h1b,
    OP_OVERFLOW_FORCE_ZERO = 6'h1c,
    OP_TFLAG_ONE = 6'h1d,
    OP_TFLAG_ZERO = 6'h1e,
    OP_HALF_CARRY_FORCE_ONE = 6'h1f,
    OP_HALF_CARRY_FORCE_ZERO = 6'h20
  } bsfx_op_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SECOND = 1'b1
  } bsfx_state_type;

  // One-hot mask for a bit index
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

endpackage

/* File: verilog/bsfx_shift_alu.sv */
`timescale 1ns/1ps
module bsfx_shift_alu
  import bsfx_pkg::*;
(
  bsfx_alu_if.alu alu // Operand in, result and flags out
);

  // Fixed-target flag ops: {valid, value, index}
  // Index is an argument so the continuous assign below wakes when it changes
  function automatic logic [4:0] fixed_flag(input bsfx_op_type op, input logic [2:0] idx);
    case (op)
      OP_CARRY_ONE: fixed_flag = {2'b11, FLAG_C};
      OP_CARRY_ZERO: fixed_flag = {2'b10, FLAG_C};
      OP_NEG_ONE: fixed_flag = {2'b11, FLAG_N};
      OP_NEG_ZERO: fixed_flag = {2'b10, FLAG_N};
      OP_ZFLAG_ONE: fixed_flag = {2'b11, FLAG_Z};
      OP_ZFLAG_ZERO: fixed_flag = {2'b10, FLAG_Z};
      OP_GLOBAL_IRQ_ON: fixed_flag = {2'b11, FLAG_I};
      OP_GLOBAL_IRQ_OFF: fixed_flag = {2'b10, FLAG_I};
      OP_SIGN_ONE: fixed_flag = {2'b11, FLAG_S};
      OP_SIGN_ZERO: fixed_flag = {2'b10, FLAG_S};
      OP_OVERFLOW_FORCE_ONE: fixed_flag = {2'b11, FLAG_V};
      OP_OVERFLOW_FORCE_ZERO: fixed_flag = {2'b10, FLAG_V};
      OP_TFLAG_ONE: fixed_flag = {2'b11, FLAG_T};
      OP_TFLAG_ZERO: fixed_flag = {2'b10, FLAG_T};
      OP_HALF_CARRY_FORCE_ONE: fixed_flag = {2'b11, FLAG_H};
      OP_HALF_CARRY_FORCE_ZERO: fixed_flag = {2'b10, FLAG_H};
      OP_STATUS_BIT_FORCE_ONE: fixed_flag = {2'b11, idx};
      OP_STATUS_BIT_FORCE_ZERO: fixed_flag = {2'b10, idx};
      default: fixed_flag = 5'h00;
    endcase
  endfunction

  logic [4:0] ff;
  logic shift_op;
  logic carry_new;
  logic [7:0] a;

  assign a = alu.operand;
  assign ff = fixed_flag(alu.op, alu.bit_sel);

  // Shift and rotate datapath, carry out taken from the bit shifted away
  always_comb begin
    shift_op = 1'b1;
    carry_new = a[0];
    alu.result = a;
    case (alu.op)
      OP_SHIFT_LEFT_LOGICAL: begin
        alu.result = {a[6:0], 1'b0}; // RL5
        carry_new = a[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: alu.result = {1'b0, a[7:1]}; // RL6
      OP_ROTATE_LEFT_THRU_CARRY: begin
        alu.result = {a[6:0], alu.flags_in[FLAG_C]}; // RL7
        carry_new = a[7];
      end
      OP_ROTATE_RIGHT_THRU_CARRY: alu.result = {alu.flags_in[FLAG_C], a[7:1]}; // RL8
      OP_SHIFT_RIGHT_ARITH: alu.result = {a[7], a[7:1]}; // RL9
      OP_NIBBLE_SWAP: begin
        alu.result = {a[3:0], a[7:4]}; // RL10
        shift_op = 1'b0;
      end
      OP_TRANSFER_FLAG_TO_REG_BIT: begin
        alu.result = alu.flags_in[FLAG_T] ? (a | bit_mask(alu.bit_sel)) // RL12
                                          : (a & ~bit_mask(alu.bit_sel));
        shift_op = 1'b0;
      end
      default: shift_op = 1'b0;
    endcase
  end

  // Flag update; only Z, C, N and V move on shifts, S and H are left alone
  always_comb begin
    alu.flags_out = alu.flags_in;
    if (shift_op) begin
      alu.flags_out[FLAG_C] = carry_new; // RL5 RL6 RL7 RL8 RL9
      alu.flags_out[FLAG_Z] = (alu.result == 8'h00);
      alu.flags_out[FLAG_N] = alu.result[7];
      alu.flags_out[FLAG_V] = alu.result[7] ^ carry_new;
    end else if (alu.op == OP_REG_BIT_TO_TRANSFER_FLAG) begin
      alu.flags_out[FLAG_T] = a[alu.bit_sel]; // RL11
    end else if (ff[4]) begin
      alu.flags_out[ff[2:0]] = ff[3]; // RL13 RL14 RL15 RL18
    end
  end

  assign alu.reg_we = shift_op || (alu.op == OP_NIBBLE_SWAP) || (alu.op == OP_TRANSFER_FLAG_TO_REG_BIT);
  assign alu.flags_we = shift_op || (alu.op == OP_REG_BIT_TO_TRANSFER_FLAG) || ff[4];

endmodule
